// ---- hdl/bstm_pkg.sv ----
// Purpose: Shared constants and types for the bus stall time-out monitor
// Assumes: 16-bit register bus, one clock domain at 25 MHz
// Notes: Register addresses are word addresses on the plain register port
package bstm_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] CTRL_ADDR = 16'h9000;
	localparam logic [15:0] IRQ_STAT_ADDR = 16'h9001;
	localparam logic [15:0] IRQ_MASK_ADDR = 16'h9002;
	localparam logic [15:0] IPORT_ERR_ADDR = 16'h0302;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_PERIPH_EN_BIT = 0;
	localparam int CTRL_EXT_EN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam int IPORT_ICACHE_BIT = 12;
	localparam int IRQ_CPU_BIT = 0;
	localparam int IRQ_DMA_BIT = 1;
	localparam int IRQ_ICACHE_BIT = 2;
	localparam int IRQ_W = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
	localparam logic [15:0] RDATA_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Timing: stall limit in CPU clock cycles
	// ----------------------------------------------------------------
	localparam int STALL_LIMIT_CYC = 512;
	localparam int CNT_W = 10;
	typedef logic [CNT_W-1:0] bstm_cnt_t;
	localparam bstm_cnt_t STALL_LAST = bstm_cnt_t'(STALL_LIMIT_CYC - 1);
	localparam bstm_cnt_t CNT_RESET = 10'h000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic start;
		logic to_periph_off;
		logic to_ext_mem;
		logic icache_fetch;
		logic ack;
	} bstm_acc_s;

	typedef struct packed {
		logic periph;
		logic ext;
		logic icache;
	} bstm_kind_s;

	localparam bstm_kind_s KIND_RESET = 3'h0;

	typedef enum logic {
		ST_IDLE,
		ST_WAIT
	} bstm_state_e;

endpackage : bstm_pkg

// ---- hdl/bstm_stall_cnt.sv ----
// Purpose: Stall cycle counter for one bus requester
// Assumes: Access inputs synchronous to clk_i; start is a one-cycle pulse
// Notes: Raises expire_o for one cycle after the stall limit without ack
`timescale 1ns/1ps
`default_nettype none
module bstm_stall_cnt
	import bstm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire bstm_acc_s acc_i,
	output logic expire_o,
	output bstm_kind_s kind_o
);

	bstm_state_e state_r, state_nxt;
	bstm_cnt_t cnt_r, cnt_nxt;
	bstm_kind_s kind_r, kind_nxt;
	logic expire_r, expire_nxt;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		kind_nxt = kind_r;
		expire_nxt = 1'b0;
		// New access always restarts, even over a pending one
		if (acc_i.start) begin
			state_nxt = ST_WAIT;
			cnt_nxt = CNT_RESET;
			kind_nxt.periph = acc_i.to_periph_off;
			kind_nxt.ext = acc_i.to_ext_mem;
			kind_nxt.icache = acc_i.icache_fetch;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					cnt_nxt = CNT_RESET;
				end
				ST_WAIT: begin
					if (acc_i.ack) begin
						state_nxt = ST_IDLE;
					end else if (cnt_r == STALL_LAST) begin
						state_nxt = ST_IDLE;
						expire_nxt = 1'b1;
					end else begin
						cnt_nxt = cnt_r + 10'h001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_r <= ST_IDLE;
			cnt_r <= CNT_RESET;
			kind_r <= KIND_RESET;
			expire_r <= 1'b0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			kind_r <= kind_nxt;
			expire_r <= expire_nxt;
		end
	end

	assign expire_o = expire_r;
	assign kind_o = kind_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	cnt_restart_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && acc_i.start) |=> (cnt_r == CNT_RESET && state_r == ST_WAIT))
		else $error("stall counter not restarted by new access");
	expire_limit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(expire_r) |-> ($past(cnt_r) == STALL_LAST && $past(state_r) == ST_WAIT))
		else $error("expiry without full stall count");

endmodule : bstm_stall_cnt
`default_nettype wire

// ---- hdl/bstm_top.sv ----
// Purpose: Bus stall time-out monitor for CPU and DMA accesses
// Assumes: Requesters flag each access with a start pulse and end it by ack
// Notes: One clock; ce_i low freezes every flip-flop
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Stalled access to off peripheral errors after 512
// - Peripheral enable bit 0, resets one
// - CPU time-out raises bus error interrupt
// - DMA time-out sets DMA flag and interrupt
// - External memory enable bit 1, resets zero
// - Cache fetch time-out sets bit 12 flag
module bstm_top
	import bstm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire bstm_acc_s cpu_acc_i,
	input wire bstm_acc_s dma_acc_i,
	input wire logic dma_flag_clr_i,
	output logic cpu_timeout_err_o,
	output logic dma_timeout_err_o,
	output logic dma_timeout_flag_o,
	output logic bus_error_irq_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Set wins over clear so no event is lost
	function automatic logic [IRQ_W-1:0] sticky(input logic [IRQ_W-1:0] old_v,
		input logic [IRQ_W-1:0] set_v, input logic [IRQ_W-1:0] clr_v);
		sticky = (old_v & ~clr_v) | set_v;
	endfunction : sticky

	function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_a);
		hit = (a == reg_a);
	endfunction : hit

	// ----------------------------------------------------------------
	// Stall counters
	// ----------------------------------------------------------------
	logic cpu_expire, dma_expire;
	bstm_kind_s cpu_kind, dma_kind;

	bstm_stall_cnt u_cpu_cnt (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.acc_i(cpu_acc_i),
		.expire_o(cpu_expire),
		.kind_o(cpu_kind)
	);

	bstm_stall_cnt u_dma_cnt (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.acc_i(dma_acc_i),
		.expire_o(dma_expire),
		.kind_o(dma_kind)
	);

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic periph_stall_err_en_r, periph_stall_err_en_nxt;
	logic ext_mem_stall_err_en_r, ext_mem_stall_err_en_nxt;
	logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
	logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
	logic instr_cache_expiry_err_r, instr_cache_expiry_err_nxt;
	logic dma_flag_r, dma_flag_nxt;
	logic cpu_err_r, cpu_err_nxt;
	logic dma_err_r, dma_err_nxt;
	logic irq_r, irq_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic cpu_to, dma_to, icache_to;
	logic [IRQ_W-1:0] ev_set, ev_clr;
	logic [15:0] ctrl_view, iport_view;

	// ----------------------------------------------------------------
	// Time-out qualification
	// ----------------------------------------------------------------
	// Enables are sampled at expiry, so clearing one mid-stall
	// suppresses the error of an access already pending
	always_comb begin
		cpu_to = cpu_expire && ((cpu_kind.periph && periph_stall_err_en_r)
			|| (cpu_kind.ext && ext_mem_stall_err_en_r));
		dma_to = dma_expire && ((dma_kind.periph && periph_stall_err_en_r)
			|| (dma_kind.ext && ext_mem_stall_err_en_r));
		icache_to = cpu_expire && cpu_kind.icache && cpu_kind.ext && ext_mem_stall_err_en_r;
	end

	always_comb begin
		ctrl_view = 16'h0000;
		ctrl_view[CTRL_PERIPH_EN_BIT] = periph_stall_err_en_r;
		ctrl_view[CTRL_EXT_EN_BIT] = ext_mem_stall_err_en_r;
		iport_view = 16'h0000;
		iport_view[IPORT_ICACHE_BIT] = instr_cache_expiry_err_r;
	end

	// ----------------------------------------------------------------
	// Register port and events
	// ----------------------------------------------------------------
	always_comb begin
		periph_stall_err_en_nxt = periph_stall_err_en_r;
		ext_mem_stall_err_en_nxt = ext_mem_stall_err_en_r;
		irq_mask_nxt = irq_mask_r;
		ev_set = '0;
		ev_clr = '0;
		rdata_nxt = RDATA_RESET;
		if (wr_i) begin
			if (hit(addr_i, CTRL_ADDR)) begin
				periph_stall_err_en_nxt = wdata_i[CTRL_PERIPH_EN_BIT];
				ext_mem_stall_err_en_nxt = wdata_i[CTRL_EXT_EN_BIT];
			end
			if (hit(addr_i, IRQ_MASK_ADDR)) begin
				irq_mask_nxt = wdata_i[IRQ_W-1:0];
			end
			if (hit(addr_i, IRQ_STAT_ADDR)) begin
				ev_clr = wdata_i[IRQ_W-1:0];
			end
		end
		if (rd_i) begin
			if (hit(addr_i, CTRL_ADDR)) begin
				rdata_nxt = ctrl_view;
			end else if (hit(addr_i, IRQ_STAT_ADDR)) begin
				rdata_nxt = {13'h0000, irq_stat_r};
			end else if (hit(addr_i, IRQ_MASK_ADDR)) begin
				rdata_nxt = {13'h0000, irq_mask_r};
			end else if (hit(addr_i, IPORT_ERR_ADDR)) begin
				rdata_nxt = iport_view;
			end
		end
		ev_set[IRQ_CPU_BIT] = cpu_to;
		ev_set[IRQ_DMA_BIT] = dma_to;
		ev_set[IRQ_ICACHE_BIT] = icache_to;
		irq_stat_nxt = sticky(irq_stat_r, ev_set, ev_clr);
		// Error flag is read-only; a read of its register clears it
		instr_cache_expiry_err_nxt = (instr_cache_expiry_err_r && !(rd_i && hit(addr_i, IPORT_ERR_ADDR)))
			|| icache_to;
		dma_flag_nxt = (dma_flag_r && !dma_flag_clr_i) || dma_to;
		cpu_err_nxt = cpu_to;
		dma_err_nxt = dma_to;
		irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			periph_stall_err_en_r <= CTRL_RESET[CTRL_PERIPH_EN_BIT];
			ext_mem_stall_err_en_r <= CTRL_RESET[CTRL_EXT_EN_BIT];
			irq_stat_r <= IRQ_RESET;
			irq_mask_r <= IRQ_RESET;
			instr_cache_expiry_err_r <= 1'b0;
			dma_flag_r <= 1'b0;
			cpu_err_r <= 1'b0;
			dma_err_r <= 1'b0;
			irq_r <= 1'b0;
			rdata_r <= RDATA_RESET;
		end else if (ce_i) begin
			periph_stall_err_en_r <= periph_stall_err_en_nxt;
			ext_mem_stall_err_en_r <= ext_mem_stall_err_en_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			instr_cache_expiry_err_r <= instr_cache_expiry_err_nxt;
			dma_flag_r <= dma_flag_nxt;
			cpu_err_r <= cpu_err_nxt;
			dma_err_r <= dma_err_nxt;
			irq_r <= irq_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_o = rdata_r;
	assign cpu_timeout_err_o = cpu_err_r;
	assign dma_timeout_err_o = dma_err_r;
	assign dma_timeout_flag_o = dma_flag_r;
	assign bus_error_irq_o = irq_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	localparam int LIM = 512;

	// Cycles since the last CPU start with no ack, saturating
	logic [10:0] cpu_stall_q;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cpu_stall_q <= 11'h000;
		end else if (ce_i) begin
			if (cpu_acc_i.start) begin
				cpu_stall_q <= 11'h001;
			end else if (cpu_acc_i.ack || cpu_stall_q == 11'h000) begin
				cpu_stall_q <= 11'h000;
			end else if (cpu_stall_q != 11'h7FF) begin
				cpu_stall_q <= cpu_stall_q + 11'h001;
			end
		end
	end

	cpu_err_time_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(cpu_timeout_err_o) |-> ($past(cpu_stall_q) == 11'(LIM + 1)))
		else $error("cpu time-out not exactly at stall limit");
	periph_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && cpu_expire && cpu_kind.periph && !cpu_kind.ext && !periph_stall_err_en_r)
		|=> !cpu_timeout_err_o)
		else $error("peripheral time-out while disabled");
	ext_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && dma_expire && dma_kind.ext && !dma_kind.periph) |=> (dma_timeout_err_o == $past(ext_mem_stall_err_en_r)))
		else $error("external time-out not following its enable");
	ctrl_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && rd_i && addr_i == CTRL_ADDR) |=> (rdata_o[15:2] == 14'h0000))
		else $error("control upper bits not zero");
	bus_irq_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(cpu_timeout_err_o && irq_mask_r[IRQ_CPU_BIT]) |-> bus_error_irq_o)
		else $error("cpu time-out did not raise bus error");
	dma_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		dma_timeout_err_o |-> (dma_timeout_flag_o && irq_stat_r[IRQ_DMA_BIT]))
		else $error("dma time-out flag or status missing");
	icache_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(instr_cache_expiry_err_r) |-> ($past(ext_mem_stall_err_en_r) && cpu_timeout_err_o))
		else $error("cache flag set without gated time-out");
	set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ce_i && dma_to && dma_flag_clr_i) |=> dma_timeout_flag_o)
		else $error("clear beat a simultaneous set");
	ctrl_reset_a: assert property (@(posedge clk_i)
		!rst_b_i |=> (periph_stall_err_en_r && !ext_mem_stall_err_en_r))
		else $error("control reset value wrong");

	cpu_to_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(cpu_timeout_err_o));
	dma_to_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(dma_timeout_flag_o));
	icache_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(instr_cache_expiry_err_r));
	irq_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(bus_error_irq_o));

endmodule : bstm_top
`default_nettype wire

// ---- verif/bstm_req_model.sv ----
// Purpose: Behavioural bus requester and slow peripheral facing one monitor channel
// Assumes: go_i is a one-cycle pulse driven by the bench after a rising edge
// Notes: ack_dly_i of zero never acknowledges, modelling a disabled peripheral
`timescale 1ns/1ps
`default_nettype none
module bstm_req_model
	import bstm_pkg::*;
(
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [2:0] kind_i,
	input wire logic [10:0] ack_dly_i,
	output bstm_acc_s acc_o
);
	logic [10:0] cnt_r;
	logic [2:0] kind_r;

	initial begin
		cnt_r = 11'h000;
		kind_r = 3'h0;
		acc_o = '0;
	end

	// ----------------------------------------------------------------
	// Access generation
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		acc_o.start <= go_i;
		acc_o.ack <= (cnt_r == ack_dly_i) && (ack_dly_i != 11'h000);
		if (go_i) begin
			kind_r <= kind_i;
			cnt_r <= 11'h001;
		end else if (cnt_r != 11'h000) begin
			cnt_r <= cnt_r + 11'h001;
		end
		// Kind bits only qualify start; show the inverse elsewhere so nothing leans on them
		{acc_o.to_periph_off, acc_o.to_ext_mem, acc_o.icache_fetch} <= go_i ? kind_i : ~kind_r;
	end
endmodule : bstm_req_model
`default_nettype wire

// ---- verif/bstm_top_tb.sv ----
// Purpose: Self-checking bench for the bus stall time-out monitor
// Assumes: Register port answers one cycle after a read strobe
// Notes: Latency is counted in edges from the start edge to the error pulse
`timescale 1ns/1ps
`default_nettype none
module bstm_top_tb
	import bstm_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic dma_flag_clr_i = 1'b0;
	logic go_cpu = 1'b0;
	logic go_dma = 1'b0;
	logic [2:0] kind = 3'h0;
	logic [10:0] dly = 11'h000;
	logic [15:0] rdata_o;
	logic cpu_timeout_err_o;
	logic dma_timeout_err_o;
	logic dma_timeout_flag_o;
	logic bus_error_irq_o;
	bstm_acc_s cpu_acc_i;
	bstm_acc_s dma_acc_i;
	logic [15:0] lat;
	int num_errors = 0;
	int total_checks = 0;

	always #20 clk_i = ~clk_i;

	bstm_req_model i_cpu_req (.clk_i(clk_i), .go_i(go_cpu), .kind_i(kind), .ack_dly_i(dly), .acc_o(cpu_acc_i));
	bstm_req_model i_dma_req (.clk_i(clk_i), .go_i(go_dma), .kind_i(kind), .ack_dly_i(dly), .acc_o(dma_acc_i));

	bstm_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cpu_acc_i(cpu_acc_i), .dma_acc_i(dma_acc_i),
		.dma_flag_clr_i(dma_flag_clr_i), .cpu_timeout_err_o(cpu_timeout_err_o),
		.dma_timeout_err_o(dma_timeout_err_o), .dma_timeout_flag_o(dma_timeout_flag_o),
		.bus_error_irq_o(bus_error_irq_o));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		check(rdata_o, exp);
	endtask : rd_chk

	// Selects the output after the edge; an argument would be sampled too early
	task automatic chk_bit(input logic sel_flag, input logic exp);
		@(posedge clk_i);
		#1;
		check({15'h0000, sel_flag ? dma_timeout_flag_o : bus_error_irq_o}, {15'h0000, exp});
	endtask : chk_bit

	// Opens an access, optionally restarts it at edge rs, returns error latency or zero
	task automatic run(input logic dma, input logic [2:0] k, input logic [10:0] d, input int rs);
		int n;
		lat = 16'h0000;
		@(posedge clk_i);
		kind <= k;
		dly <= d;
		go_cpu <= !dma;
		go_dma <= dma;
		for (n = 1; n <= 900; n++) begin
			@(posedge clk_i);
			go_cpu <= (n == rs) && !dma;
			go_dma <= (n == rs) && dma;
			#1;
			if (lat == 16'h0000 && (dma ? dma_timeout_err_o : cpu_timeout_err_o) === 1'b1) begin
				lat = 16'(n - 2);
			end
		end
	endtask : run

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		rd_chk(CTRL_ADDR, 16'h0001);
		rd_chk(IRQ_STAT_ADDR, 16'h0000);
		rd_chk(IRQ_MASK_ADDR, 16'h0000);
		rd_chk(IPORT_ERR_ADDR, 16'h0000);
		rd_chk(16'h1234, 16'h0000);
		wr(CTRL_ADDR, 16'hFFFF);
		rd_chk(CTRL_ADDR, 16'h0003);
		wr(CTRL_ADDR, 16'h0001);
	endtask : t_regs

	task automatic t_cpu;
		run(1'b0, 3'h4, 11'h000, 0);
		check(lat, 16'd513);
		chk_bit(1'b0, 1'b0);
		rd_chk(IRQ_STAT_ADDR, 16'h0001);
		wr(IRQ_MASK_ADDR, 16'h0007);
		chk_bit(1'b0, 1'b1);
		wr(IRQ_STAT_ADDR, 16'h0001);
		chk_bit(1'b0, 1'b0);
	endtask : t_cpu

	task automatic t_ack_restart;
		run(1'b0, 3'h4, 11'd512, 0);
		check(lat, 16'h0000);
		run(1'b0, 3'h4, 11'h000, 300);
		check(lat, 16'd813);
		wr(IRQ_STAT_ADDR, 16'h0001);
	endtask : t_ack_restart

	task automatic t_dma;
		run(1'b1, 3'h4, 11'h000, 0);
		check(lat, 16'd513);
		chk_bit(1'b1, 1'b1);
		chk_bit(1'b0, 1'b1);
		rd_chk(IRQ_STAT_ADDR, 16'h0002);
		@(posedge clk_i);
		dma_flag_clr_i <= 1'b1;
		@(posedge clk_i);
		dma_flag_clr_i <= 1'b0;
		chk_bit(1'b1, 1'b0);
		wr(IRQ_STAT_ADDR, 16'h0002);
		chk_bit(1'b0, 1'b0);
	endtask : t_dma

	task automatic t_off;
		wr(CTRL_ADDR, 16'h0000);
		run(1'b0, 3'h4, 11'h000, 0);
		check(lat, 16'h0000);
		run(1'b1, 3'h4, 11'h000, 0);
		check(lat, 16'h0000);
		rd_chk(IRQ_STAT_ADDR, 16'h0000);
		wr(CTRL_ADDR, 16'h0001);
		run(1'b0, 3'h0, 11'h000, 0);
		check(lat, 16'h0000);
	endtask : t_off

	task automatic t_ext;
		run(1'b0, 3'h3, 11'h000, 0);
		check(lat, 16'h0000);
		wr(CTRL_ADDR, 16'h0003);
		run(1'b0, 3'h3, 11'h000, 0);
		check(lat, 16'd513);
		rd_chk(IPORT_ERR_ADDR, 16'h1000);
		rd_chk(IRQ_STAT_ADDR, 16'h0005);
		rd_chk(IPORT_ERR_ADDR, 16'h0000);
		wr(IRQ_STAT_ADDR, 16'h0005);
		wr(CTRL_ADDR, 16'h0001);
		chk_bit(1'b0, 1'b0);
	endtask : t_ext

	// ----------------------------------------------------------------
	// Sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs();
		t_cpu();
		t_ack_restart();
		t_dma();
		t_off();
		t_ext();
		end_of_test();
	end

	initial begin
		#(40 * 20000);
		num_errors++;
		end_of_test();
	end
endmodule : bstm_top_tb
`default_nettype wire
